// file: hw/asp_consts.vh
// constants for the audio serial port control block
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
// register indices and reset values
`define ASP_ADDR_OUT_LOW 12'hA54
`define ASP_ADDR_OUT_HIGH 12'hA55
`define ASP_ADDR_IN_CTRL 12'hA56
`define ASP_RESET_CTRL16 16'h0000
`define ASP_RESET_CTRL8 8'h00
// output control fields
`define ASP_B_DITHER 15
`define ASP_B_LINK 14
`define ASP_B_CAPTURE 14
`define ASP_B_WC_POL 13
`define ASP_B_BC_POL 12
`define ASP_B_MASTER 11
`define ASP_F_BDIV 10:9
`define ASP_F_FDIV 8:7
`define ASP_B_PULSE 6
`define ASP_B_TDM 5
`define ASP_F_MSB 4:2
`define ASP_F_WLEN 1:0
// input control fields
`define ASP_B_IN_TDM16 5
`define ASP_B_IN_WC_POL 4
`define ASP_B_IN_BC_POL 3
`define ASP_F_IN_FMT 2:0
// core clock divide factors
`define ASP_BDIV_00 11'd24
`define ASP_BDIV_01 11'd12
`define ASP_BDIV_10 11'd6
`define ASP_BDIV_11 11'd3
`define ASP_FDIV_00 11'd1536
`define ASP_FDIV_01 11'd768
`define ASP_FDIV_10 11'd384
// msb delays in bit clocks
`define ASP_DLY_1 5'd1
`define ASP_DLY_0 5'd0
`define ASP_DLY_8 5'd8
`define ASP_DLY_12 5'd12
`define ASP_DLY_16 5'd16
// word lengths
`define ASP_WL_24 5'd24
`define ASP_WL_20 5'd20
`define ASP_WL_16 5'd16
`define ASP_WL_18 5'd18
// input format codes
`define ASP_FMT_I2S 3'h0
`define ASP_FMT_LJ 3'h1
`define ASP_FMT_TDM 3'h2
`define ASP_FMT_RJ24 3'h3
`define ASP_FMT_RJ20 3'h4
`define ASP_FMT_RJ18 3'h5
`define ASP_FMT_RJ16 3'h6
// slot geometry and dither lfsr
`define ASP_SLOT_MSB 23
`define ASP_OFS_MAX 9'h1FF
`define ASP_LFSR_SEED 16'hACE1
`define ASP_LFSR_TAPS 16'hB400
`endif

// file: hw/asp_fifo.v
// sample fifo between the audio source and the frame staging buffer
`default_nettype none
module asp_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    wire push;
    wire pop;
    integer i;

    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_reg[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem_reg[wr_reg] <= in_data;
                wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule // asp_fifo
`default_nettype wire

// file: hw/asp_ctrl.v
// audio serial port: control registers, clock generation and output serialiser
`include "asp_consts.vh"
`default_nettype none
// Overview of operation
// - dither bit adds dither to group
// - link bit with both tdm bits set merges sixteen channels on pin 0
// - capture bit puts capture data on pin 7
// - word clock polarity picks left half level
// - bit clock polarity picks data change edge
// - clock pins inputs until master bit set
// - master bit clock divides core by 24/12/6/3
// - master word clock divides core by 1536/768/384
// - frame sync type clock or one-bit pulse
// - tdm bit selects single stream per group
// - msb position delay 1/0/8/12/16 bits
// - word length 24/20/16, zeros after lsb
// - input tdm select dual eight or sixteen
// - input word polarity defines frame start edge
// - input bit polarity sets change edge
// - input format decode i2s/lj/tdm/rj
// - input polarity bits override format field
module asp_ctrl #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // register access port
    input wire [11:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output reg reg_rvalid,
    // audio samples in channel order 0..15
    input wire s_valid,
    output wire s_ready,
    input wire [23:0] s_data,
    // data capture word
    input wire [23:0] cap_data,
    // output clock pins, index 0 = channels 0-7, 1 = channels 8-15
    input wire [1:0] out_bit_clock_pin_i,
    output reg [1:0] out_bit_clock_pin_o,
    output wire [1:0] out_bit_clock_pin_oe,
    input wire [1:0] out_word_clock_pin_i,
    output reg [1:0] out_word_clock_pin_o,
    output wire [1:0] out_word_clock_pin_oe,
    // serial data pins
    output reg [7:0] out_data_pin,
    // input port configuration
    output wire in_tdm16,
    output wire in_frame_rise,
    output wire in_change_rise,
    output wire in_sample_rise,
    output wire in_fmt_i2s,
    output wire in_fmt_lj,
    output wire in_fmt_tdm,
    output wire in_fmt_rj,
    output reg [4:0] in_rj_bits
);
    reg rst_s1_reg;
    reg rst_n_s;
    reg [15:0] ctl0_reg;
    reg [15:0] ctl1_reg;
    reg [7:0] inctl_reg;
    reg [383:0] stg_reg;
    reg [383:0] act_reg;
    reg [1:0] stg_vld_reg;
    reg [3:0] fill_reg;
    reg [23:0] cap_reg;
    reg [15:0] lfsr_reg;
    wire [31:0] ctl_w;
    wire [1:0] wr_g;
    wire [1:0] chg_w;
    wire [1:0] load_w;
    wire [1:0] half_w;
    wire [1:0] ld_half;
    wire [17:0] ofs_w;
    wire [1:0] bc_lvl_w;
    wire [1:0] wc_lvl_w;
    wire tdm16;
    wire f_valid;
    wire f_ready;
    wire [23:0] f_data;
    integer h;

    function [10:0] bclk_div;
        input [1:0] code;
        begin
            case (code)
                2'h0: bclk_div = `ASP_BDIV_00;
                2'h1: bclk_div = `ASP_BDIV_01;
                2'h2: bclk_div = `ASP_BDIV_10;
                default: bclk_div = `ASP_BDIV_11;
            endcase
        end
    endfunction

    function [10:0] frame_div;
        input [1:0] code;
        begin
            case (code)
                2'h1: frame_div = `ASP_FDIV_01;
                2'h2: frame_div = `ASP_FDIV_10;
                default: frame_div = `ASP_FDIV_00;
            endcase
        end
    endfunction

    function [4:0] msb_delay;
        input [2:0] code;
        begin
            case (code)
                3'h1: msb_delay = `ASP_DLY_0;
                3'h2: msb_delay = `ASP_DLY_8;
                3'h3: msb_delay = `ASP_DLY_12;
                3'h4: msb_delay = `ASP_DLY_16;
                default: msb_delay = `ASP_DLY_1;
            endcase
        end
    endfunction

    function [4:0] word_len;
        input [1:0] code;
        begin
            case (code)
                2'h1: word_len = `ASP_WL_20;
                2'h2: word_len = `ASP_WL_16;
                default: word_len = `ASP_WL_24;
            endcase
        end
    endfunction

    // one serial bit of a slot: msb first after the delay, zeros after the lsb
    function fmt_bit;
        input [23:0] w;
        input [8:0] pos;
        input [15:0] ctl;
        input dith;
        reg [4:0] dly;
        reg [4:0] wl;
        reg [8:0] p;
        begin
            dly = msb_delay(ctl[`ASP_F_MSB]);
            wl = word_len(ctl[`ASP_F_WLEN]);
            p = pos - {4'h0, dly};
            if (pos < {4'h0, dly} || p >= {4'h0, wl}) begin
                fmt_bit = 1'b0;
            end else begin
                fmt_bit = w[5'd`ASP_SLOT_MSB - p[4:0]];
                if (ctl[`ASP_B_DITHER] && p[4:0] == wl - 5'd1) begin
                    fmt_bit = fmt_bit ^ dith;
                end
            end
        end
    endfunction

    // reset release synchroniser
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_s <= rst_s1_reg;
        end
    end

    assign ctl_w = {ctl1_reg, ctl0_reg};
    assign wr_g[0] = reg_wr && reg_addr == `ASP_ADDR_OUT_LOW;
    assign wr_g[1] = reg_wr && reg_addr == `ASP_ADDR_OUT_HIGH;
    assign tdm16 = ctl0_reg[`ASP_B_LINK] & ctl0_reg[`ASP_B_TDM] & ctl1_reg[`ASP_B_TDM];

    // register file
    always @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctl0_reg <= `ASP_RESET_CTRL16;
            ctl1_reg <= `ASP_RESET_CTRL16;
            inctl_reg <= `ASP_RESET_CTRL8;
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            if (wr_g[0]) begin
                ctl0_reg <= reg_wdata;
            end
            if (wr_g[1]) begin
                ctl1_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ASP_ADDR_IN_CTRL) begin
                inctl_reg <= reg_wdata[7:0];
            end
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ASP_ADDR_OUT_LOW: reg_rdata <= ctl0_reg;
                    `ASP_ADDR_OUT_HIGH: reg_rdata <= ctl1_reg;
                    `ASP_ADDR_IN_CTRL: reg_rdata <= {8'h00, inctl_reg};
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // input port decode; polarity bits pass straight through, format never forces them
    assign in_tdm16 = inctl_reg[`ASP_B_IN_TDM16];
    assign in_frame_rise = inctl_reg[`ASP_B_IN_WC_POL];
    assign in_change_rise = inctl_reg[`ASP_B_IN_BC_POL];
    assign in_sample_rise = ~inctl_reg[`ASP_B_IN_BC_POL];
    assign in_fmt_i2s = inctl_reg[`ASP_F_IN_FMT] == `ASP_FMT_I2S;
    assign in_fmt_lj = inctl_reg[`ASP_F_IN_FMT] == `ASP_FMT_LJ;
    assign in_fmt_tdm = inctl_reg[`ASP_F_IN_FMT] == `ASP_FMT_TDM;
    assign in_fmt_rj = inctl_reg[`ASP_F_IN_FMT] >= `ASP_FMT_RJ24 &&
                       inctl_reg[`ASP_F_IN_FMT] <= `ASP_FMT_RJ16;

    always @* begin
        case (inctl_reg[`ASP_F_IN_FMT])
            `ASP_FMT_RJ24: in_rj_bits = `ASP_WL_24;
            `ASP_FMT_RJ20: in_rj_bits = `ASP_WL_20;
            `ASP_FMT_RJ18: in_rj_bits = `ASP_WL_18;
            `ASP_FMT_RJ16: in_rj_bits = `ASP_WL_16;
            default: in_rj_bits = 5'd0;
        endcase
    end

    // sample path: fifo then a 16 word staging buffer, one half per group
    asp_fifo #(
        .WIDTH(24),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n_s),
        .in_valid(s_valid),
        .in_ready(s_ready),
        .in_data(s_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // a full half stalls the fifo until its group takes it at frame start
    assign f_ready = ~stg_vld_reg[fill_reg[3]];
    assign ld_half[0] = load_w[0];
    assign ld_half[1] = tdm16 ? load_w[0] : load_w[1];

    always @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            stg_reg <= 384'h0;
            act_reg <= 384'h0;
            stg_vld_reg <= 2'h0;
            fill_reg <= 4'h0;
            cap_reg <= 24'h000000;
            lfsr_reg <= `ASP_LFSR_SEED;
        end else begin
            if (f_valid && f_ready) begin
                stg_reg[fill_reg*24 +: 24] <= f_data;
                fill_reg <= fill_reg + 4'h1;
                if (fill_reg[2:0] == 3'h7) begin
                    stg_vld_reg[fill_reg[3]] <= 1'b1;
                end
            end
            // underrun repeats the previous frame rather than emitting garbage
            for (h = 0; h < 2; h = h + 1) begin
                if (ld_half[h] && stg_vld_reg[h]) begin
                    act_reg[h*192 +: 192] <= stg_reg[h*192 +: 192];
                    stg_vld_reg[h] <= 1'b0;
                end
            end
            if (load_w[1]) begin
                cap_reg <= cap_data;
            end
            if (|chg_w) begin
                lfsr_reg <= lfsr_reg[0] ? ((lfsr_reg >> 1) ^ `ASP_LFSR_TAPS) : (lfsr_reg >> 1);
            end
        end
    end

    // per group clocking and bit position tracking
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : grp
            wire [15:0] ctl = ctl_w[g*16 +: 16];
            wire master = ctl[`ASP_B_MASTER];
            wire tdm = ctl[`ASP_B_TDM] | (g == 0 && tdm16);
            wire pol_w = ctl[`ASP_B_WC_POL];
            wire [10:0] bdiv = bclk_div(ctl[`ASP_F_BDIV]);
            wire [10:0] fdiv = frame_div(ctl[`ASP_F_FDIV]);
            wire [10:0] bhalf = {1'b0, bdiv[10:1]};
            reg [10:0] bcnt_reg;
            reg [10:0] fcnt_reg;
            reg bc_s1_reg, bc_s2_reg, bc_s3_reg;
            reg wc_s1_reg, wc_s2_reg;
            reg wc_last_reg;
            reg half_reg;
            reg [8:0] ofs_reg;
            wire first = ctl[`ASP_B_PULSE] ? (fcnt_reg < bdiv) : (fcnt_reg < {1'b0, fdiv[10:1]});
            wire mwc = pol_w ? first : ~first;
            wire mbc = bcnt_reg >= bhalf;
            wire rise_ev = master ? (bcnt_reg == bhalf) : (~bc_s3_reg & bc_s2_reg);
            wire fall_ev = master ? (bcnt_reg == 11'd0) : (bc_s3_reg & ~bc_s2_reg);
            wire chg = ctl[`ASP_B_BC_POL] ? rise_ev : fall_ev;
            wire wc_lvl = master ? mwc : wc_s2_reg;
            wire wedge = wc_lvl != wc_last_reg;
            wire fstart = wedge && (wc_lvl == pol_w);
            wire restart = tdm ? fstart : wedge;

            assign chg_w[g] = chg;
            assign load_w[g] = chg & fstart;
            assign half_w[g] = half_reg;
            assign ofs_w[g*9 +: 9] = restart ? 9'h000 : ofs_reg;
            assign bc_lvl_w[g] = mbc;
            assign wc_lvl_w[g] = mwc;
            assign out_bit_clock_pin_oe[g] = master;
            assign out_word_clock_pin_oe[g] = master;

            always @(posedge clk or negedge rst_n_s) begin
                if (!rst_n_s) begin
                    bcnt_reg <= 11'd0;
                    fcnt_reg <= 11'd0;
                    bc_s1_reg <= 1'b0;
                    bc_s2_reg <= 1'b0;
                    bc_s3_reg <= 1'b0;
                    wc_s1_reg <= 1'b0;
                    wc_s2_reg <= 1'b0;
                    wc_last_reg <= 1'b0;
                    half_reg <= 1'b0;
                    ofs_reg <= 9'h000;
                end else begin
                    bc_s1_reg <= out_bit_clock_pin_i[g];
                    bc_s2_reg <= bc_s1_reg;
                    bc_s3_reg <= bc_s2_reg;
                    wc_s1_reg <= out_word_clock_pin_i[g];
                    wc_s2_reg <= wc_s1_reg;
                    // a write to this group's own control register realigns both of its dividers to a frame boundary
                    if (wr_g[g] || !master) begin
                        bcnt_reg <= 11'd0;
                        fcnt_reg <= 11'd0;
                    end else begin
                        bcnt_reg <= (bcnt_reg == bdiv - 11'd1) ? 11'd0 : bcnt_reg + 11'd1;
                        fcnt_reg <= (fcnt_reg == fdiv - 11'd1) ? 11'd0 : fcnt_reg + 11'd1;
                    end
                    if (chg) begin
                        wc_last_reg <= wc_lvl;
                        if (restart) begin
                            ofs_reg <= 9'h001;
                            half_reg <= tdm ? 1'b0 : (wc_lvl != pol_w);
                        end else if (ofs_reg != `ASP_OFS_MAX) begin
                            ofs_reg <= ofs_reg + 9'h001;
                        end
                    end
                end
            end
        end
    endgenerate

    // clock pin drivers, registered alongside the data pins
    always @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            out_bit_clock_pin_o <= 2'h0;
            out_word_clock_pin_o <= 2'h0;
        end else begin
            out_bit_clock_pin_o <= bc_lvl_w;
            out_word_clock_pin_o <= wc_lvl_w;
        end
    end

    // data pins: pins 0-3 follow group 0, pins 4-7 group 1
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : pin
            localparam G = k / 4;
            localparam J = k % 4;
            wire [15:0] ctl = ctl_w[G*16 +: 16];
            wire tdm_g = (G == 0) ? (ctl[`ASP_B_TDM] | tdm16) : ctl[`ASP_B_TDM];
            wire [8:0] ofs = ofs_w[G*9 +: 9];
            wire [3:0] slot = tdm_g ? ((G == 0 && tdm16) ? ofs[8:5] : {G[0], ofs[7:5]})
                                    : {G[0], J[1:0], half_w[G]};
            wire [8:0] pos = tdm_g ? {4'h0, ofs[4:0]} : ofs;
            wire [23:0] word = (ld_half[slot[3]] && stg_vld_reg[slot[3]]) ?
                               stg_reg[slot*24 +: 24] : act_reg[slot*24 +: 24];
            wire capture = (k == 7) && ctl1_reg[`ASP_B_CAPTURE];
            wire idle = !capture && ((tdm_g && J != 0) || (G == 1 && tdm16));
            wire nbit = capture ? fmt_bit(cap_reg, pos, ctl, lfsr_reg[G])
                                : fmt_bit(word, pos, ctl, lfsr_reg[G]);
            always @(posedge clk or negedge rst_n_s) begin
                if (!rst_n_s) begin
                    out_data_pin[k] <= 1'b0;
                end else if (chg_w[G]) begin
                    out_data_pin[k] <= idle ? 1'b0 : nbit;
                end
            end
        end
    endgenerate
endmodule // asp_ctrl
`default_nettype wire

// file: testbench/asp_ctrl_sva.sv
// assertion checker for the audio serial port control block
`default_nettype none
module asp_ctrl_sva (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    // pins
    input wire logic [1:0] out_bit_clock_pin_o,
    input wire logic [1:0] out_bit_clock_pin_oe,
    input wire logic [1:0] out_word_clock_pin_oe,
    input wire logic [7:0] out_data_pin,
    // input decodes
    input wire logic in_tdm16,
    input wire logic in_frame_rise,
    input wire logic in_change_rise,
    input wire logic in_sample_rise,
    input wire logic in_fmt_rj,
    input wire logic [4:0] in_rj_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh0_reg, sh1_reg, exp_rd;
    logic [7:0] sh2_reg;
    logic [6:0] quiet_reg;
    logic [4:0] rj_exp;
    // shadows of what was last written
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sh0_reg <= 16'h0000;
            sh1_reg <= 16'h0000;
            sh2_reg <= 8'h00;
            quiet_reg <= 7'h00;
        end else begin
            if (reg_wr && reg_addr == 12'hA54) sh0_reg <= reg_wdata;
            if (reg_wr && reg_addr == 12'hA55) sh1_reg <= reg_wdata;
            if (reg_wr && reg_addr == 12'hA56) sh2_reg <= reg_wdata[7:0];
            if (reg_wr) quiet_reg <= 7'h00;
            else if (quiet_reg != 7'h7F) quiet_reg <= quiet_reg + 7'h01;
        end
    end
    always_comb begin
        case (reg_addr)
            12'hA54: exp_rd = sh0_reg;
            12'hA55: exp_rd = sh1_reg;
            12'hA56: exp_rd = {8'h00, sh2_reg};
            default: exp_rd = 16'h0000;
        endcase
        case (sh2_reg[2:0])
            3'h3: rj_exp = 5'h18;
            3'h4: rj_exp = 5'h14;
            3'h5: rj_exp = 5'h12;
            3'h6: rj_exp = 5'h10;
            default: rj_exp = 5'h00;
        endcase
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_read;
        reg_rd && !reg_wr;
    endsequence
    sequence s_quiet3;
        !reg_wr [*3];
    endsequence
    a_read_latency: assert property (s_read |=> reg_rvalid)
        else $error("read answer missing");
    a_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read answer without strobe");
    a_read_data: assert property (s_read |=> reg_rdata == $past(exp_rd))
        else $error("read data differs from written value");
    a_clock_drive: assert property (
        out_bit_clock_pin_oe == {sh1_reg[11], sh0_reg[11]}
        && out_word_clock_pin_oe == {sh1_reg[11], sh0_reg[11]})
        else $error("clock pin drive does not follow master bit");
    a_in_decode: assert property (
        in_tdm16 == sh2_reg[5] && in_frame_rise == sh2_reg[4]
        && in_change_rise == sh2_reg[3] && in_sample_rise == !sh2_reg[3])
        else $error("input polarity decode wrong");
    a_rj_width: assert property (
        in_rj_bits == rj_exp && in_fmt_rj == (rj_exp != 5'h00))
        else $error("right-justified decode wrong");
    a_bclk_div3: assert property (
        sh0_reg[11] && sh0_reg[10:9] == 2'b11 && quiet_reg > 7'd8
        && $rose(out_bit_clock_pin_o[0]) ##0 s_quiet3 |=> $rose(out_bit_clock_pin_o[0]))
        else $error("bit clock period not three");
    a_data_edge: assert property (
        sh0_reg[11] && !sh0_reg[12] && quiet_reg > 7'd8 && $changed(out_data_pin[0])
        |-> $fell(out_bit_clock_pin_o[0]))
        else $error("data moved off the falling bit clock edge");
    a_tdm_idle: assert property (
        sh0_reg[11] && sh0_reg[5] && !sh0_reg[14] && quiet_reg == 7'h7F
        |-> out_data_pin[3:1] == 3'h0)
        else $error("unused pins active in tdm");
    a_link_idle: assert property (
        sh0_reg[11] && sh0_reg[14] && sh0_reg[5] && sh1_reg[5] && quiet_reg == 7'h7F
        |-> !out_data_pin[4])
        else $error("pin four active in linked stream");
endmodule // asp_ctrl_sva
`default_nettype wire

// file: testbench/asp_codec_model.sv
// far-side codec model supplying slave bit and word clocks
`default_nettype none
module asp_codec_model (
    // clock and enable
    input wire logic clk,
    input wire logic en,
    // serial clocks toward the port
    output logic bclk,
    output logic wclk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] n_reg;
    // 256 bits of 16 core cycles; clocks stand still when disabled
    always_ff @(posedge clk) n_reg <= en ? n_reg + 12'h001 : 12'h000;
    assign bclk = en & n_reg[3];
    assign wclk = en & n_reg[11];
endmodule // asp_codec_model
`default_nettype wire

// file: testbench/asp_ctrl_tb_top.sv
// self-checking bench for the audio serial port control block
`default_nettype none
module asp_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] W = 24'hC0003F;
    localparam int D[8] = '{1, 0, 8, 12, 16, 1, 1, 1};
    localparam int L[4] = '{24, 20, 16, 24};
    localparam int MW[8] = '{0, 5, 8, 14, 16, 20, 3, 28};
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, s_valid = 1'b0, en = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [15:0] reg_wdata = 16'h0000;
    wire cb, cw, s_ready, reg_rvalid;
    wire [15:0] reg_rdata;
    wire [1:0] bo, boe, wo, woe;
    wire [7:0] dp;
    wire [3:0] fmt;
    wire [4:0] rjb;
    wire [1:0] bc = (boe & bo) | (~boe & {cb, 1'b0});
    int miscompares = 0;
    int n_checks = 0;
    always #2.5 clk = ~clk;
    asp_ctrl uut (
        .clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .s_valid, .s_ready, .s_data(W), .cap_data(W),
        .out_bit_clock_pin_i({cb, 1'b0}), .out_bit_clock_pin_o(bo),
        .out_bit_clock_pin_oe(boe), .out_word_clock_pin_i({cw, 1'b0}),
        .out_word_clock_pin_o(wo), .out_word_clock_pin_oe(woe), .out_data_pin(dp),
        .in_tdm16(), .in_frame_rise(), .in_change_rise(), .in_sample_rise(),
        .in_fmt_i2s(fmt[3]), .in_fmt_lj(fmt[2]), .in_fmt_tdm(fmt[1]), .in_fmt_rj(fmt[0]),
        .in_rj_bits(rjb)
    );
    asp_codec_model codec (.clk, .en, .bclk(cb), .wclk(cw));
    function automatic int ones(input int nb);
        int r = 0;
        for (int i = 0; i < nb; i++) r += W[23 - i];
        return r;
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", what, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", 1, reg_rvalid);
        chk("rdata", e, reg_rdata);
    endtask
    // first-to-last rise spacing, any start phase
    task automatic per(input int s, input int p, input int h, input int n);
        int r = 0, d = 0, hc = 0, dl = 0, hl = 0;
        logic v, pv = 1'b1;
        repeat (n) begin
            @(posedge clk);
            #1;
            v = s ? wo[0] : bo[0];
            if (v && !pv) begin
                r++;
                dl = d;
                hl = hc;
            end
            if (r > 0) d++;
            if (r > 0 && v) hc++;
            pv = v;
        end
        chk("rises", 1, r >= 2);
        chk("period", (r - 1) * p, dl);
        if (h > 0) chk("high", (r - 1) * h, hl);
    endtask
    task automatic cnt(input int g, input int p, input int nb, input int e);
        int c = 0, k = 0, t = 0;
        logic pv = bc[g];
        while (k < nb) begin
            @(posedge clk);
            #1;
            if (++t > 20000) begin
                miscompares++;
                conclude();
            end
            if (bc[g] && !pv) k++;
            if (bc[g] && !pv) c += dp[p];
            pv = bc[g];
        end
        chk("ones", e, c);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rd(12'hA54, 16'h0000);
        rd(12'hA55, 16'h0000);
        rd(12'hA56, 16'h0000);
        chk("oe", 4'h0, {boe, woe});
        wr(12'hA56, 16'hFFFF);
        rd(12'hA56, 16'h00FF);
        wr(12'hA57, 16'h1234);
        rd(12'hA57, 16'h0000);
        $display("test registers done");
        for (int f = 0; f < 7; f++) begin
            wr(12'hA56, 16'(f) | ((f % 2) ? 16'h0018 : 16'h0020));
            #1;
            chk("format", {f == 0, f == 1, f == 2, f > 2,
                f > 2 ? 5'(f == 5 ? 18 : L[f - 3 - f / 6]) : 5'h00}, {fmt, rjb});
        end
        $display("test input decode done");
        @(posedge clk) s_valid <= 1'b1;
        for (int i = 0; i < 100 && s_ready; i++) @(posedge clk);
        #1;
        chk("ready", 0, s_ready);
        $display("test fifo full done");
        for (int c = 0; c < 4; c++) begin
            wr(12'hA54, 16'h0800 | 16'(c << 9));
            #1;
            chk("oe", 4'h5, {boe, woe});
            per(0, 24 >> c, 0, 200);
        end
        for (int f = 0; f < 3; f++) begin
            wr(12'hA54, 16'h0800 | 16'(f << 7));
            per(1, 1536 >> f, 768 >> f, 3500);
        end
        wr(12'hA54, 16'h2940);
        per(1, 384, 24, 900);
        $display("test master clocks done");
        for (int i = 0; i < 8; i++) begin
            wr(12'hA54, 16'h0C20 | 16'(MW[i]));
            repeat (1600) @(posedge clk);
            cnt(0, 0, 256, 8 * ones(L[MW[i] % 4] < 32 - D[MW[i] >> 2] ?
                L[MW[i] % 4] : 32 - D[MW[i] >> 2]));
        end
        cnt(0, 1, 256, 0);
        wr(12'hA54, 16'h0C00);
        repeat (1600) @(posedge clk);
        cnt(0, 1, 256, 2 * ones(24));
        $display("test serial data done");
        wr(12'hA55, 16'h0020);
        wr(12'hA54, 16'h4E20);
        repeat (1600) @(posedge clk);
        cnt(0, 0, 512, 16 * ones(24));
        wr(12'hA54, 16'h0000);
        en <= 1'b1;
        repeat (8200) @(posedge clk);
        cnt(1, 4, 256, 8 * ones(24));
        en <= 1'b0;
        $display("test link and slave done");
        conclude();
    end
endmodule // asp_ctrl_tb_top
bind asp_ctrl asp_ctrl_sva chk_i (
    .clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .out_bit_clock_pin_o, .out_bit_clock_pin_oe, .out_word_clock_pin_oe, .out_data_pin,
    .in_tdm16, .in_frame_rise, .in_change_rise, .in_sample_rise, .in_fmt_rj, .in_rj_bits
);
`default_nettype wire
